/* File: rtl/tmb_bridge.sv */
// tunnel-mode command relay and interrupt request control
//
// How it works
// - select bit 0 decides if field detection raises a request.
// - host mask suppresses field request even when selected.
// - with contact supply, pending request stays low after field loss.
// - without supply, field powers request; losing field releases pin.
// - read-direction address match clears any pending request.
// - reader tunnel command raises a request by pulling pin low.
// - serial commands accepted from the moment the pin falls.
// - inquiry is 0x28; answer: status, big-endian address, length.
// - address upper byte bit7=0, bit6=1, bits5:4 carry mode.
// - status goes to host first; reply to reader only afterwards.
// - inquiry and answer accepted only in tunnel mode.
// - inquiry wait starts at pin fall; expiry declares timeout.
// - answer wait starts once the last inquiry response byte has left the buffer.
// - other serial commands' issue-to-response span is not counted.
// - command start is the address acknowledge, not start condition.
// - answer raises completion request only when option flag is 0.
// - reader read code is 0x06 or 0xB0.
// - reader write code is 0x08 or 0xD6.
// - option bit gates completion request for register and tunnel cmds.
// - tunnel detection request cannot be masked.
// - request pin driven low signals a pending request.
`timescale 1ns/1ns
`include "tmb_map.svh"
module tmb_bridge #(
    parameter int P_TICK_CYCLES = `TMB_TICK_CYCLES
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_contact_supply,
    input  wire logic       i_field_present,
    input  wire logic       i_tunnel_mode,
    input  wire logic [3:0] i_irq_source_select,
    input  wire logic       i_field_irq_mask,
    input  wire logic       i_serial_irq_option,
    input  wire logic [7:0] i_inquiry_wait_time,
    input  wire logic [7:0] i_answer_wait_time,
    input  wire logic       i_rf_tunnel_cmd,
    input  wire logic       i_rf_proximity,
    input  wire logic [7:0] i_rf_cmd_code,
    input  wire logic [1:0] i_rf_mode,
    input  wire logic [3:0] i_rf_addr_hi,
    input  wire logic [7:0] i_rf_addr_lo,
    input  wire logic [7:0] i_rf_len,
    input  wire logic       i_addr_ack,
    input  wire logic       i_addr_read,
    input  wire logic       i_cmd_valid,
    input  wire logic       i_cmd_first,
    input  wire logic       i_cmd_last,
    input  wire logic [7:0] i_cmd_data,
    input  wire logic       i_other_done,
    input  wire logic       i_other_is_reg,
    input  wire logic       i_rsp_ready,
    output logic            o_rsp_valid,
    output logic [7:0]      o_rsp_data,
    output logic            o_irq_request_pin_n_out,
    output logic            o_irq_request_pin_n_oe,
    output logic            o_rf_data_valid,
    output logic [7:0]      o_rf_data,
    output logic            o_rf_send,
    output logic            o_rf_ok,
    output logic            o_rf_abandon,
    output logic            o_timeout
);
    // ==================================================
    // functions
    function automatic logic tmb_rf_code_ok(input logic prox, input logic [7:0] code);
        tmb_rf_code_ok = prox ? (code == `TMB_RF_RD_PROX || code == `TMB_RF_WR_PROX)
                              : (code == `TMB_RF_RD_JIS || code == `TMB_RF_WR_JIS);
    endfunction

    function automatic logic tmb_expired(input logic [7:0] cnt, input logic [7:0] lim);
        tmb_expired = (cnt >= lim);
    endfunction

    // ==================================================
    // pin synchronisers: three flops, change taken when last two agree
    logic [2:0] sup_sync;
    logic [2:0] fld_sync;
    logic       supply_ok;
    logic       field_ok;
    logic       field_q;

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sup_sync  <= 3'h0;
            fld_sync  <= 3'h0;
            supply_ok <= 1'b0;
            field_ok  <= 1'b0;
            field_q   <= 1'b0;
        end else begin
            sup_sync <= {sup_sync[1:0], i_contact_supply};
            fld_sync <= {fld_sync[1:0], i_field_present};
            if (sup_sync[1] == sup_sync[2]) begin
                supply_ok <= sup_sync[2];
            end
            if (fld_sync[1] == fld_sync[2]) begin
                field_ok <= fld_sync[2];
            end
            field_q <= field_ok;
        end
    end

    // ==================================================
    // state and captured reader command
    tmb_pkg::tmb_state_t state;
    tmb_pkg::tmb_state_t next_state;
    tmb_pkg::tmb_byte_t  cap_hi;
    tmb_pkg::tmb_byte_t  cap_lo;
    tmb_pkg::tmb_byte_t  cap_len;
    logic                ans_ok;
    logic                pending;
    logic                pending_q;
    logic                timing;
    logic                paused;
    logic [7:0]          wait_cnt;
    logic [15:0]         tick_cnt;
    logic [1:0]          push_idx;
    logic                push_done;

    // ==================================================
    // decode
    wire power_lost   = !supply_ok && !field_ok;
    wire field_rise   = field_ok && !field_q;
    wire field_irq    = field_rise && i_irq_source_select[`TMB_SEL_FIELD_BIT]
                        && !i_field_irq_mask;
    wire rf_accept    = i_rf_tunnel_cmd && (state == tmb_pkg::TMB_IDLE)
                        && tmb_rf_code_ok(i_rf_proximity, i_rf_cmd_code);
    wire cmd_byte0    = i_cmd_valid && i_cmd_first;
    wire is_inquiry   = cmd_byte0 && (i_cmd_data == `TMB_CMD_INQUIRY);
    wire is_ans_ok    = cmd_byte0 && (i_cmd_data == `TMB_CMD_ANS_OK);
    wire is_ans_err   = cmd_byte0 && (i_cmd_data == `TMB_CMD_ANS_ERR);
    wire inq_take     = is_inquiry && i_tunnel_mode && (state == tmb_pkg::TMB_WAIT_INQ);
    wire ans_take     = (is_ans_ok || is_ans_err) && i_tunnel_mode
                        && (state == tmb_pkg::TMB_WAIT_ANS);
    wire in_wait      = (state == tmb_pkg::TMB_WAIT_INQ) || (state == tmb_pkg::TMB_WAIT_ANS);
    wire wait_lim_hit = (state == tmb_pkg::TMB_WAIT_INQ)
                        ? tmb_expired(wait_cnt, i_inquiry_wait_time)
                        : tmb_expired(wait_cnt, i_answer_wait_time);
    wire tick         = (tick_cnt == 16'(P_TICK_CYCLES - 1));
    wire time_out     = in_wait && timing && wait_lim_hit;
    wire sending      = (state == tmb_pkg::TMB_SEND_QRSP) || (state == tmb_pkg::TMB_SEND_ARSP);
    wire entering_snd = inq_take || (state == tmb_pkg::TMB_RECV_ANS && i_cmd_valid && i_cmd_last)
                        || (ans_take && i_cmd_last);
    wire ans_entry    = entering_snd && !inq_take;
    wire cmpl_irq     = (entering_snd && !i_serial_irq_option)
                        || (i_other_done && (!i_other_is_reg || !i_serial_irq_option));
    wire set_pending  = rf_accept || field_irq || cmpl_irq;
    wire clr_pending  = i_addr_ack && i_addr_read;
    wire pin_fall     = pending && !pending_q;

    // ==================================================
    // response generator feeding the host-side buffer
    logic       push_ready;
    logic [7:0] push_data;
    wire        push_valid = sending && !push_done;
    wire        push_fire  = push_valid && push_ready;
    wire [1:0]  push_last  = (state == tmb_pkg::TMB_SEND_QRSP) ? `TMB_QRSP_LAST : 2'h0;
    wire        rsp_sent   = sending && push_done && !o_rsp_valid;

    always_comb begin
        push_data = `TMB_ST_OK;
        if (state == tmb_pkg::TMB_SEND_QRSP) begin
            case (push_idx)
                2'h1:    push_data = cap_hi;
                2'h2:    push_data = cap_lo;
                2'h3:    push_data = cap_len;
                default: push_data = `TMB_ST_OK;
            endcase
        end
    end

    tmb_skid_buf u_rsp_buf (
        .i_ref_clk   (i_ref_clk),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (push_valid),
        .i_in_data   (push_data),
        .o_in_ready  (push_ready),
        .o_out_valid (o_rsp_valid),
        .o_out_data  (o_rsp_data),
        .i_out_ready (i_rsp_ready)
    );

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            push_idx  <= 2'h0;
            push_done <= 1'b0;
        end else if (!sending) begin
            push_idx  <= 2'h0;
            push_done <= 1'b0;
        end else if (push_fire) begin
            push_idx <= push_idx + 2'h1;
            if (push_idx == push_last) begin
                push_done <= 1'b1;
            end
        end
    end

    // ==================================================
    // state machine
    always_comb begin
        next_state = state;
        case (state)
            tmb_pkg::TMB_IDLE: begin
                if (rf_accept) begin
                    next_state = tmb_pkg::TMB_WAIT_INQ;
                end
            end
            tmb_pkg::TMB_WAIT_INQ: begin
                if (time_out) begin
                    next_state = tmb_pkg::TMB_IDLE;
                end else if (inq_take) begin
                    next_state = tmb_pkg::TMB_SEND_QRSP;
                end
            end
            tmb_pkg::TMB_SEND_QRSP: begin
                if (rsp_sent) begin
                    next_state = tmb_pkg::TMB_WAIT_ANS;
                end
            end
            tmb_pkg::TMB_WAIT_ANS: begin
                if (time_out) begin
                    next_state = tmb_pkg::TMB_IDLE;
                end else if (ans_take) begin
                    next_state = i_cmd_last ? tmb_pkg::TMB_SEND_ARSP : tmb_pkg::TMB_RECV_ANS;
                end
            end
            tmb_pkg::TMB_RECV_ANS: begin
                if (i_cmd_valid && i_cmd_last) begin
                    next_state = tmb_pkg::TMB_SEND_ARSP;
                end
            end
            tmb_pkg::TMB_SEND_ARSP: begin
                if (rsp_sent) begin
                    next_state = tmb_pkg::TMB_IDLE;
                end
            end
            default: next_state = tmb_pkg::TMB_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= tmb_pkg::TMB_IDLE;
        end else if (power_lost) begin
            state <= tmb_pkg::TMB_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ==================================================
    // capture of the reader command for the inquiry response
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cap_hi  <= 8'h00;
            cap_lo  <= 8'h00;
            cap_len <= 8'h00;
            ans_ok  <= 1'b0;
        end else begin
            if (rf_accept) begin
                cap_hi  <= {`TMB_ADDR_MARK, i_rf_mode, i_rf_addr_hi};
                cap_lo  <= i_rf_addr_lo;
                cap_len <= i_rf_len;
            end
            if (ans_take) begin
                ans_ok <= is_ans_ok;
            end
        end
    end

    // ==================================================
    // interrupt request pin; set wins over clear, power loss wins all
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pending   <= 1'b0;
            pending_q <= 1'b0;
        end else begin
            pending_q <= pending;
            if (power_lost) begin
                pending <= 1'b0;
            end else if (set_pending) begin
                pending <= 1'b1;
            end else if (clr_pending) begin
                pending <= 1'b0;
            end
        end
    end

    // open drain: only ever pulls low
    assign o_irq_request_pin_n_out = 1'b0;
    assign o_irq_request_pin_n_oe  = pending;

    // ==================================================
    // wait timers; paused from address ack of a foreign command to its reply
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            timing   <= 1'b0;
            paused   <= 1'b0;
            wait_cnt <= 8'h00;
            tick_cnt <= 16'h0000;
        end else begin
            if (!in_wait || time_out) begin
                timing <= 1'b0;
            end else if (state == tmb_pkg::TMB_WAIT_INQ && !timing && (pin_fall || pending_q)) begin
                timing   <= 1'b1;
                wait_cnt <= 8'h00;
                tick_cnt <= 16'h0000;
            end
            if (rsp_sent && state == tmb_pkg::TMB_SEND_QRSP) begin
                timing   <= 1'b1;
                wait_cnt <= 8'h00;
                tick_cnt <= 16'h0000;
            end
            if (!in_wait || i_other_done || cmd_byte0 && (inq_take || ans_take)) begin
                paused <= 1'b0;
            end else if (i_addr_ack && !i_addr_read) begin
                paused <= 1'b1;
            end
            if (timing && in_wait && !paused && !(i_addr_ack && !i_addr_read)) begin
                if (tick) begin
                    tick_cnt <= 16'h0000;
                    if (wait_cnt != 8'hFF) begin
                        wait_cnt <= wait_cnt + 8'h01;
                    end
                end else begin
                    tick_cnt <= tick_cnt + 16'h0001;
                end
            end
        end
    end

    // ==================================================
    // reader-side outputs; reply released only after host status drained
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rf_data_valid <= 1'b0;
            o_rf_data       <= 8'h00;
            o_rf_send       <= 1'b0;
            o_rf_ok         <= 1'b0;
            o_rf_abandon    <= 1'b0;
            o_timeout       <= 1'b0;
        end else begin
            o_rf_data_valid <= (state == tmb_pkg::TMB_RECV_ANS) && i_cmd_valid && ans_ok;
            if ((state == tmb_pkg::TMB_RECV_ANS) && i_cmd_valid) begin
                o_rf_data <= i_cmd_data;
            end
            o_rf_send    <= rsp_sent && (state == tmb_pkg::TMB_SEND_ARSP);
            if (ans_entry) begin
                o_rf_ok <= (state == tmb_pkg::TMB_RECV_ANS) ? ans_ok : is_ans_ok;
            end
            o_rf_abandon <= time_out || (power_lost && state != tmb_pkg::TMB_IDLE);
            o_timeout    <= time_out;
        end
    end
endmodule

/* File: inc/tmb_map.svh */
// constants of the tunnel-mode interrupt bridge
`ifndef TMB_MAP_SVH
`define TMB_MAP_SVH

// ==================================================
// host command codes
`define TMB_CMD_INQUIRY   8'h28
`define TMB_CMD_ANS_OK    8'hF8
`define TMB_CMD_ANS_ERR   8'hE8

// ==================================================
// reader command codes (card standard / proximity)
`define TMB_RF_RD_JIS     8'h06
`define TMB_RF_RD_PROX    8'hB0
`define TMB_RF_WR_JIS     8'h08
`define TMB_RF_WR_PROX    8'hD6

// ==================================================
// field positions and fixed values
`define TMB_SEL_FIELD_BIT 0
`define TMB_ADDR_MARK     2'b01
`define TMB_QRSP_LAST     2'h3
`define TMB_ST_OK         8'h00
`define TMB_ST_ERR        8'h01

// ==================================================
// timing: wait times count in ticks of this length
`define TMB_TICK_US       1000
`define TMB_CLK_MHZ       10
`define TMB_TICK_CYCLES   (`TMB_TICK_US * `TMB_CLK_MHZ)

`endif

/* File: inc/tmb_pkg.sv */
// types of the tunnel-mode interrupt bridge
package tmb_pkg;

    typedef enum logic [2:0] {
        TMB_IDLE,
        TMB_WAIT_INQ,
        TMB_SEND_QRSP,
        TMB_WAIT_ANS,
        TMB_RECV_ANS,
        TMB_SEND_ARSP
    } tmb_state_t;

    typedef logic [7:0] tmb_byte_t;

endpackage

/* File: rtl/tmb_skid_buf.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module tmb_skid_buf (
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_in_valid,
    input  wire logic [7:0] i_in_data,
    output logic            o_in_ready,
    output logic            o_out_valid,
    output logic [7:0]      o_out_data,
    input  wire logic       i_out_ready
);
    logic [7:0] mem [0:1];
    logic       wr_idx;
    logic       rd_idx;
    logic [1:0] count;
    wire        push = i_in_valid && o_in_ready;
    wire        pop  = o_out_valid && i_out_ready;

    assign o_in_ready  = (count != 2'h2);
    assign o_out_valid = (count != 2'h0);
    assign o_out_data  = mem[rd_idx];

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_idx <= 1'b0;
            rd_idx <= 1'b0;
            count  <= 2'h0;
            mem[0] <= 8'h00;
            mem[1] <= 8'h00;
        end else begin
            if (push) begin
                mem[wr_idx] <= i_in_data;
                wr_idx      <= ~wr_idx;
            end
            if (pop) begin
                rd_idx <= ~rd_idx;
            end
            if (push && !pop) begin
                count <= count + 2'h1;
            end else if (pop && !push) begin
                count <= count - 2'h1;
            end
        end
    end
endmodule

/* File: dv/tmb_bridge_sva.sv */
// port checker for the tunnel-mode interrupt bridge
`timescale 1ns/1ns
module tmb_bridge_chk #(
    parameter int P_TICK_CYCLES = 10000
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_tunnel_mode,
    input  wire logic [3:0] i_irq_source_select,
    input  wire logic       i_serial_irq_option,
    input  wire logic       i_rf_tunnel_cmd,
    input  wire logic       i_addr_ack,
    input  wire logic       i_addr_read,
    input  wire logic       i_cmd_valid,
    input  wire logic       i_cmd_first,
    input  wire logic [7:0] i_cmd_data,
    input  wire logic       i_other_done,
    input  wire logic       i_rsp_ready,
    input  wire logic       o_rsp_valid,
    input  wire logic [7:0] o_rsp_data,
    input  wire logic       o_irq_request_pin_n_out,
    input  wire logic       o_irq_request_pin_n_oe,
    input  wire logic       o_rf_data_valid,
    input  wire logic [7:0] o_rf_data,
    input  wire logic       o_rf_send,
    input  wire logic       o_rf_abandon,
    input  wire logic       o_timeout
);
    // ==================================================
    // clocking
    default clocking dc @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);

    // ==================================================
    // assertions
    pin_low_a: assert property (o_irq_request_pin_n_oe |-> !o_irq_request_pin_n_out)
        else $error("request pin enabled but not driving low");
    pin_clear_a: assert property (i_addr_ack && i_addr_read && !i_rf_tunnel_cmd && !i_cmd_valid
        && !i_other_done && !i_irq_source_select[0] |=> !o_irq_request_pin_n_oe)
        else $error("read address match left the request pending");
    tmo_abandon_a: assert property (o_timeout |-> o_rf_abandon)
        else $error("timeout without abandoning the transaction");
    rsp_hold_a: assert property (o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_data))
        else $error("response byte lost while host stalled");
    send_after_a: assert property (o_rf_send |-> !o_rsp_valid)
        else $error("reply started before answer status drained");
    mode_refuse_a: assert property (!i_tunnel_mode && i_cmd_valid && i_cmd_first && !o_rsp_valid
        && !$past(i_cmd_valid) |-> ##2 !o_rsp_valid)
        else $error("command answered outside tunnel mode");
    inq_status_a: assert property (i_cmd_valid && i_cmd_first && i_cmd_data == 8'h28 && !o_rsp_valid
        |-> ##2 (!o_rsp_valid || o_rsp_data == 8'h00))
        else $error("inquiry response does not open with status");
    reply_pair_a: assert property (o_rf_data_valid |-> $past(i_cmd_valid) && !$past(i_cmd_first)
        && o_rf_data == $past(i_cmd_data))
        else $error("reply byte differs from answer byte");
    opt_quiet_a: assert property (i_serial_irq_option && i_cmd_valid && !o_irq_request_pin_n_oe
        && !i_rf_tunnel_cmd && !i_other_done && !i_irq_source_select[0] |=> !o_irq_request_pin_n_oe)
        else $error("completion request raised with option flag set");
endmodule

bind tmb_bridge tmb_bridge_chk #(.P_TICK_CYCLES(P_TICK_CYCLES)) chk_i (.i_ref_clk, .i_reset_n,
    .i_tunnel_mode, .i_irq_source_select, .i_serial_irq_option, .i_rf_tunnel_cmd, .i_addr_ack,
    .i_addr_read, .i_cmd_valid, .i_cmd_first, .i_cmd_data, .i_other_done, .i_rsp_ready, .o_rsp_valid,
    .o_rsp_data, .o_irq_request_pin_n_out, .o_irq_request_pin_n_oe, .o_rf_data_valid, .o_rf_data,
    .o_rf_send, .o_rf_abandon, .o_timeout);

/* File: dv/tmb_host_model.sv */
// host-side sink of the response byte stream
`timescale 1ns/1ns
module tmb_host_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_stall,
    input  wire logic       i_rsp_valid,
    input  wire logic [7:0] i_rsp_data,
    output logic            o_rsp_ready
);
    logic [7:0] got[$];
    logic [1:0] cnt;
    // stalling takes one word in four so the buffer must hold back
    always @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rsp_ready <= 1'b0;
            cnt <= 2'h0;
        end else begin
            if (i_rsp_valid && o_rsp_ready) begin
                got.push_back(i_rsp_data);
            end
            cnt <= cnt + 2'h1;
            o_rsp_ready <= !i_stall || (cnt == 2'h3);
        end
    end
endmodule

/* File: dv/tb_tunnel_mode_irq_bridge.sv */
// testbench of the tunnel-mode interrupt bridge
`timescale 1ns/1ns
module tb_tunnel_mode_irq_bridge;
    logic       i_ref_clk, i_reset_n, i_contact_supply, i_field_present, i_tunnel_mode, i_field_irq_mask;
    logic       i_serial_irq_option, i_rf_tunnel_cmd, i_rf_proximity, i_addr_ack, i_addr_read, i_cmd_valid;
    logic       i_cmd_first, i_cmd_last, i_other_done, i_other_is_reg, i_rsp_ready, stall;
    logic [3:0] i_irq_source_select, i_rf_addr_hi;
    logic [1:0] i_rf_mode;
    logic [7:0] i_inquiry_wait_time, i_answer_wait_time, i_rf_cmd_code, i_rf_addr_lo, i_rf_len, i_cmd_data;
    logic       o_rsp_valid, o_irq_request_pin_n_out, o_irq_request_pin_n_oe, o_rf_data_valid, o_rf_send;
    logic       o_rf_ok, o_rf_abandon, o_timeout;
    logic [7:0] o_rsp_data, o_rf_data;
    int         failures, tests_run;

    tmb_bridge #(.P_TICK_CYCLES(10)) uut (.*);
    tmb_host_model host (.i_ref_clk, .i_reset_n, .i_stall(stall), .i_rsp_valid(o_rsp_valid),
        .i_rsp_data(o_rsp_data), .o_rsp_ready(i_rsp_ready));

    // ==================================================
    // helpers
    task print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task bound(input int n);
        if (n >= 200) begin
            chk("wait bound", 8'h00, 8'h01);
            print_verdict;
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    task rf_cmd(input logic [7:0] code, input logic prox);
        tick(1);
        {i_rf_tunnel_cmd, i_rf_cmd_code, i_rf_proximity} = {1'b1, code, prox};
        tick(1);
        i_rf_tunnel_cmd = 1'b0;
    endtask
    task host_byte(input logic [7:0] d, input logic f, input logic l);
        tick(1);
        {i_cmd_valid, i_cmd_first, i_cmd_last, i_cmd_data} = {1'b1, f, l, d};
        tick(1);
        i_cmd_valid = 1'b0;
    endtask
    task ack_read;
        tick(1);
        {i_addr_ack, i_addr_read} = 2'b11;
        tick(1);
        i_addr_ack = 1'b0;
    endtask
    // foreign write command: address ack, gap cycles, then its reply finishes
    task other_cmd(input int gap);
        tick(1);
        {i_addr_ack, i_addr_read} = 2'b10;
        tick(1);
        i_addr_ack = 1'b0;
        tick(gap);
        i_other_done = 1'b1;
        tick(1);
        i_other_done = 1'b0;
    endtask
    // one full relay, answered normally when ok is set
    task automatic txn(input logic [7:0] code, input logic prox, input logic ok);
        int n;
        host.got.delete();
        rf_cmd(code, prox);
        chk("pin raised", o_irq_request_pin_n_oe, 8'h01);
        chk("pin drive", o_irq_request_pin_n_out, 8'h00);
        ack_read;
        chk("pin freed", o_irq_request_pin_n_oe, 8'h00);
        host_byte(8'h28, 1'b1, 1'b1);
        tick(1);
        chk("inquiry irq", o_irq_request_pin_n_oe, {7'h00, !i_serial_irq_option});
        ack_read;
        for (n = 0; n < 200 && host.got.size() < 4; n++) tick(1);
        bound(n);
        chk("inq status", host.got[0], 8'h00);
        chk("inq addr hi", host.got[1], 8'h63);
        chk("inq addr lo", host.got[2], 8'h5A);
        chk("inq length", host.got[3], 8'h02);
        tick(3);
        host_byte(ok ? 8'hF8 : 8'hE8, 1'b1, !ok);
        if (ok) begin
            host_byte(8'hA5, 1'b0, 1'b0);
            chk("reply byte", o_rf_data_valid ? o_rf_data : 8'h00, 8'hA5);
            host_byte(8'h3C, 1'b0, 1'b1);
            chk("reply byte", o_rf_data_valid ? o_rf_data : 8'h00, 8'h3C);
        end
        for (n = 0; n < 200 && o_rf_send !== 1'b1; n++) tick(1);
        bound(n);
        chk("status first", host.got.size(), 8'h05);
        chk("ans status", host.got[4], 8'h00);
        chk("reply kind", o_rf_ok, {7'h00, ok});
        tick(4);
        chk("answer irq", o_irq_request_pin_n_oe, {7'h00, !i_serial_irq_option});
        ack_read;
        chk("pin idle", o_irq_request_pin_n_oe, 8'h00);
    endtask

    // ==================================================
    // scenarios
    task sc_relay;
        logic [7:0] codes [4] = '{8'h06, 8'h08, 8'hB0, 8'hD6};
        for (int i = 0; i < 4; i++) txn(codes[i], i[1], i[0] == 1'b0);
    endtask
    task sc_option;
        i_serial_irq_option = 1'b1;
        txn(8'hB0, 1'b1, 1'b1);
        i_serial_irq_option = 1'b0;
    endtask
    task automatic sc_timeout;
        int n;
        host.got.delete();
        i_tunnel_mode = 1'b0;
        rf_cmd(8'h06, 1'b0);
        host_byte(8'h28, 1'b1, 1'b1);
        other_cmd(9);
        chk("refused inquiry", host.got.size(), 8'h00);
        for (n = 0; n < 200 && o_timeout !== 1'b1; n++) tick(1);
        bound(n);
        // 3 ticks of 10 cycles; 2 counted before the foreign command, 11 held off by it
        chk("inquiry wait", (n >= 27 && n <= 31), 8'h01);
        chk("abandoned", o_rf_abandon, 8'h01);
        i_tunnel_mode = 1'b1;
        ack_read;
    endtask
    task sc_field;
        {i_irq_source_select, i_field_irq_mask, i_field_present} = {4'h1, 2'b11};
        tick(8);
        chk("masked field", o_irq_request_pin_n_oe, 8'h00);
        i_field_present = 1'b0;
        tick(8);
        {i_field_irq_mask, i_field_present} = 2'b01;
        tick(8);
        chk("field irq", o_irq_request_pin_n_oe, 8'h01);
        i_field_present = 1'b0;
        tick(8);
        chk("held on supply", o_irq_request_pin_n_oe, 8'h01);
        ack_read;
        {i_field_present, i_contact_supply} = 2'b10;
        tick(8);
        chk("field powered", o_irq_request_pin_n_oe, 8'h01);
        i_field_present = 1'b0;
        tick(8);
        chk("power lost", o_irq_request_pin_n_oe, 8'h00);
        {i_contact_supply, i_irq_source_select} = {1'b1, 4'h0};
        tick(8);
    endtask

    // ==================================================
    // run
    initial begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        {i_reset_n, i_field_present, i_field_irq_mask, i_serial_irq_option, i_rf_tunnel_cmd} = '0;
        {i_rf_proximity, i_addr_ack, i_addr_read, i_cmd_valid, i_cmd_first, i_cmd_last} = '0;
        {i_other_done, i_other_is_reg, i_irq_source_select, i_rf_cmd_code, i_cmd_data} = '0;
        {i_contact_supply, i_tunnel_mode, stall} = 3'b111;
        {i_rf_mode, i_rf_addr_hi, i_rf_addr_lo, i_rf_len} = {2'b10, 4'h3, 8'h5A, 8'h02};
        {i_inquiry_wait_time, i_answer_wait_time} = {8'h03, 8'h05};
        failures = 0;
        tests_run = 0;
        tick(12);
        i_reset_n = 1'b1;
        tick(6);
        sc_relay;
        sc_option;
        sc_timeout;
        sc_field;
        print_verdict;
    end
endmodule
